// ### rtl/sccr_pkg.sv
// Package: register map, field layout, reset values and types of the readout block
package sccr_pkg;
  localparam int          NUM_CH        = 2;
  // Register byte addresses
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_CMD      = 8'h04;
  localparam logic [7:0]  ADDR_GAIN_CH1 = 8'h08;
  localparam logic [7:0]  ADDR_OFFS_CH1 = 8'h0C;
  localparam logic [7:0]  ADDR_GAIN_CH2 = 8'h10;
  localparam logic [7:0]  ADDR_OFFS_CH2 = 8'h14;
  localparam logic [7:0]  ADDR_CSP_CH1  = 8'h18;
  localparam logic [7:0]  ADDR_CSP_CH2  = 8'h1C;
  localparam logic [7:0]  ADDR_AST_CH1  = 8'h20;
  localparam logic [7:0]  ADDR_AST_CH2  = 8'h24;
  localparam logic [7:0]  ADDR_ADV_CH1  = 8'h28;
  localparam logic [7:0]  ADDR_ADV_CH2  = 8'h2C;
  localparam logic [7:0]  ADDR_DUAL     = 8'h30;
  localparam logic [7:0]  ADDR_PMEM     = 8'h34;
  // Field positions
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_RATE_LSB = 16;
  localparam int          CMD_TRIG_BIT  = 0;
  localparam int          HI_LSB        = 16;
  localparam int          LO_LSB        = 0;
  localparam int          GAIN_W        = 11;
  localparam int          PMEM_STAT_LSB = 16;
  // Reset values
  localparam logic [3:0]  MODE_RESET    = 4'h0;
  localparam logic [15:0] RATE_RESET    = 16'h1000;
  localparam logic [10:0] GAIN_RESET    = 11'h400;
  localparam logic [15:0] OFFS_RESET    = 16'h0000;
  // Behaviour constants
  localparam logic [3:0]  MODE_CALIB    = 4'h5;
  localparam logic [11:0] GAIN_HALF     = 12'h400;
  localparam int          GAIN_SHIFT    = 11;
  localparam logic [13:0] MAG_MAX       = 14'h3FFF;
  localparam logic [15:0] DEV_SETTLED   = 16'h0141;

  typedef enum logic [1:0] {
    SCCR_BUS_IDLE = 2'b01,
    SCCR_BUS_ACK  = 2'b10
  } sccr_bus_t;

  typedef struct packed {
    logic [31:0] corr;
    logic [15:0] angle;
    logic [15:0] step;
    logic [1:0]  quad;
    logic [15:0] qcnt;
    logic [15:0] qvis;
    logic [15:0] hi;
    logic        primed;
  } sccr_chan_state_t;
endpackage

// ### rtl/sccr_chan_if.sv
// Interface: settings into and results out of one channel
`timescale 1ns/1ps
`default_nettype none
interface sccr_chan_if;
  logic        sample_valid;
  logic [15:0] raw_sin;
  logic [15:0] raw_cos;
  logic [15:0] turn;
  logic [15:0] deviation;
  logic [15:0] sin_off;
  logic [15:0] cos_off;
  logic [10:0] sin_gain;
  logic [10:0] cos_gain;
  logic [15:0] rate;
  logic        calib;
  logic        trig;
  logic [31:0] corr_word;
  logic [15:0] angle;
  logic [15:0] step;
  logic [15:0] hi_word;
  modport chan (input sample_valid, raw_sin, raw_cos, turn, deviation, sin_off, cos_off,
                input sin_gain, cos_gain, rate, calib, trig,
                output corr_word, angle, step, hi_word);
  modport top  (output sample_valid, raw_sin, raw_cos, turn, deviation, sin_off, cos_off,
                output sin_gain, cos_gain, rate, calib, trig,
                input corr_word, angle, step, hi_word);
endinterface
`default_nettype wire

// ### rtl/sccr_chan.sv
// Module: per-channel correction, angle, phase step and quadrant counter
`timescale 1ns/1ps
`default_nettype none
module sccr_chan
  import sccr_pkg::*;
(
  // Clock and reset
  input  wire logic   clock_i,
  input  wire logic   rst_b_i,
  // Channel link
  sccr_chan_if.chan   ch
);
  sccr_chan_state_t s_q, s_d;

  function automatic logic [15:0] sm_word(input logic signed [18:0] v);
    logic [18:0] mag;
    mag = v[18] ? 19'(-v) : 19'(v);
    if (mag > {5'h00, MAG_MAX}) begin
      mag = {5'h00, MAG_MAX};
    end
    return {v[18], 1'b0, mag[13:0]};
  endfunction

  logic signed [16:0] sum_sin, sum_cos;
  logic signed [29:0] prod_sin, prod_cos;
  logic [31:0]        ang_prod;
  logic [15:0]        ang_new;
  logic signed [16:0] diff;
  logic [16:0]        half;
  logic [1:0]         qd;

  always_comb begin
    s_d      = s_q;
    sum_sin  = 17'(signed'({ch.raw_sin[15], ch.raw_sin})) + 17'(signed'({ch.sin_off[15], ch.sin_off}));
    sum_cos  = 17'(signed'({ch.raw_cos[15], ch.raw_cos})) + 17'(signed'({ch.cos_off[15], ch.cos_off}));
    prod_sin = 30'(sum_sin * signed'({1'b0, GAIN_HALF + {1'b0, ch.sin_gain}}));
    prod_cos = 30'(sum_cos * signed'({1'b0, GAIN_HALF + {1'b0, ch.cos_gain}}));
    ang_prod = ch.turn * ch.rate;
    ang_new  = ang_prod[31:16];
    half     = {2'b00, ch.rate[15:1]};
    diff     = signed'({1'b0, ang_new}) - signed'({1'b0, s_q.angle});
    qd       = ch.turn[15:14] - s_q.quad;
    if (ch.calib ? ch.trig : ch.sample_valid) begin
      s_d.corr[31:16] = sm_word(prod_sin[29:11]);
      s_d.corr[15:0]  = sm_word(prod_cos[29:11]);
    end
    if (ch.sample_valid) begin
      if (diff > signed'(half)) begin
        diff = diff - signed'({1'b0, ch.rate});
      end else if (diff < -signed'(half)) begin
        diff = diff + signed'({1'b0, ch.rate});
      end
      s_d.angle  = ang_new;
      s_d.step   = s_q.primed ? diff[15:0] : 16'h0000;
      s_d.quad   = ch.turn[15:14];
      s_d.primed = 1'b1;
      if (s_q.primed && qd == 2'b01) begin
        s_d.qcnt = s_q.qcnt + 16'h0001;
      end else if (s_q.primed && qd == 2'b11) begin
        s_d.qcnt = s_q.qcnt - 16'h0001;
      end
    end
    if (ch.calib && ch.trig) begin
      s_d.qvis = s_q.qcnt;
    end
    s_d.hi = ch.calib ? s_q.qvis : ch.deviation;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ch.corr_word = s_q.corr;
  assign ch.angle     = s_q.angle;
  assign ch.step      = s_q.step;
  assign ch.hi_word   = s_q.hi;
endmodule
`default_nettype wire

// ### rtl/sccr_top.sv
// Module: sine/cosine interpolation readout registers on an Avalon-MM slave
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sccr_top
  import sccr_pkg::*;
(
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     rst_b_i,
  // Avalon-MM slave
  input  wire logic [7:0]               avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic      [31:0]              avs_readdata_o,
  output logic                          avs_waitrequest_o,
  // Sampled channel inputs
  input  wire logic [sccr_pkg::NUM_CH-1:0]        sample_valid_i,
  input  wire logic [sccr_pkg::NUM_CH-1:0][15:0]  raw_sin_i,
  input  wire logic [sccr_pkg::NUM_CH-1:0][15:0]  raw_cos_i,
  input  wire logic [sccr_pkg::NUM_CH-1:0][15:0]  turn_i,
  input  wire logic [sccr_pkg::NUM_CH-1:0][15:0]  deviation_i,
  // Calibration trigger pin
  input  wire logic                     trig_i,
  // Parameter-memory status
  input  wire logic                     mem_load_valid_i,
  input  wire logic                     erase_active_i,
  input  wire logic                     write_active_i,
  input  wire logic                     memory_busy_i,
  input  wire logic                     memory_locked_i
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    sccr_bus_t                    bus;
    logic                         wreq;
    logic [31:0]                  rdata;
    logic [3:0]                   mode;
    logic [15:0]                  rate;
    logic [NUM_CH-1:0][10:0]      gsin;
    logic [NUM_CH-1:0][10:0]      gcos;
    logic [NUM_CH-1:0][15:0]      osin;
    logic [NUM_CH-1:0][15:0]      ocos;
    logic                         trig_prev;
    logic                         trig;
    logic [4:0]                   stat;
  } sccr_top_state_t;

  sccr_top_state_t s_q, s_d;

  logic [NUM_CH-1:0][31:0] corr_w;
  logic [NUM_CH-1:0][15:0] angle_w;
  logic [NUM_CH-1:0][15:0] step_w;
  logic [NUM_CH-1:0][15:0] hi_w;
  logic [31:0]             dual_w;
  logic [31:0]             rmux;
  logic                    calib;
  logic                    cmd_trig;
  logic [31:0]             wmerge;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // Channels
  // ****************************************
  assign calib = (s_q.mode == MODE_CALIB);

  sccr_chan_if ch_if [NUM_CH] ();

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign ch_if[gi].sample_valid = sample_valid_i[gi];
      assign ch_if[gi].raw_sin      = raw_sin_i[gi];
      assign ch_if[gi].raw_cos      = raw_cos_i[gi];
      assign ch_if[gi].turn         = turn_i[gi];
      assign ch_if[gi].deviation    = deviation_i[gi];
      assign ch_if[gi].sin_off      = s_q.osin[gi];
      assign ch_if[gi].cos_off      = s_q.ocos[gi];
      assign ch_if[gi].sin_gain     = s_q.gsin[gi];
      assign ch_if[gi].cos_gain     = s_q.gcos[gi];
      assign ch_if[gi].rate         = s_q.rate;
      assign ch_if[gi].calib        = calib;
      assign ch_if[gi].trig         = s_q.trig;
      assign corr_w[gi]             = ch_if[gi].corr_word;
      assign angle_w[gi]            = ch_if[gi].angle;
      assign step_w[gi]             = ch_if[gi].step;
      assign hi_w[gi]               = ch_if[gi].hi_word;
      sccr_chan u_chan (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .ch      (ch_if[gi])
      );
    end
  endgenerate

  assign dual_w = {angle_w[1], angle_w[0]};

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rmux = 32'h0000_0000;
    case (avs_address_i)
      ADDR_CTRL: begin
        rmux[CTRL_RATE_LSB +: 16] = s_q.rate;
        rmux[CTRL_MODE_LSB +: 4]  = s_q.mode;
      end
      ADDR_GAIN_CH1: begin
        rmux[HI_LSB +: GAIN_W] = s_q.gsin[0];
        rmux[LO_LSB +: GAIN_W] = s_q.gcos[0];
      end
      ADDR_GAIN_CH2: begin
        rmux[HI_LSB +: GAIN_W] = s_q.gsin[1];
        rmux[LO_LSB +: GAIN_W] = s_q.gcos[1];
      end
      ADDR_OFFS_CH1: rmux = {s_q.osin[0], s_q.ocos[0]};
      ADDR_OFFS_CH2: rmux = {s_q.osin[1], s_q.ocos[1]};
      ADDR_CSP_CH1:  rmux = corr_w[0];
      ADDR_CSP_CH2:  rmux = corr_w[1];
      ADDR_AST_CH1:  rmux = {step_w[0], angle_w[0]};
      ADDR_AST_CH2:  rmux = {step_w[1], angle_w[1]};
      ADDR_ADV_CH1:  rmux = {hi_w[0], angle_w[0]};
      ADDR_ADV_CH2:  rmux = {hi_w[1], angle_w[1]};
      ADDR_DUAL:     rmux = dual_w;
      ADDR_PMEM:     rmux[PMEM_STAT_LSB +: 5] = s_q.stat;
      default:       rmux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Bus handshake and register writes
  // ****************************************
  always_comb begin
    s_d           = s_q;
    cmd_trig      = 1'b0;
    wmerge        = 32'h0000_0000;
    s_d.trig_prev = trig_i;
    // Status sampled every cycle, never altered by software
    s_d.stat = {mem_load_valid_i, erase_active_i, write_active_i,
                memory_busy_i, memory_locked_i};
    case (s_q.bus)
      SCCR_BUS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          s_d.bus   = SCCR_BUS_ACK;
          s_d.rdata = avs_read_i ? rmux : 32'h0000_0000;
        end
      end
      SCCR_BUS_ACK: begin
        s_d.bus = SCCR_BUS_IDLE;
        if (avs_write_i) begin
          case (avs_address_i)
            ADDR_CTRL: begin
              wmerge   = be_merge({s_q.rate, 12'h000, s_q.mode},
                                  avs_writedata_i, avs_byteenable_i);
              s_d.rate = wmerge[CTRL_RATE_LSB +: 16];
              s_d.mode = wmerge[CTRL_MODE_LSB +: 4];
            end
            ADDR_CMD: begin
              cmd_trig = avs_byteenable_i[0] && avs_writedata_i[CMD_TRIG_BIT];
            end
            ADDR_GAIN_CH1: begin
              wmerge      = be_merge({5'h00, s_q.gsin[0], 5'h00, s_q.gcos[0]},
                                     avs_writedata_i, avs_byteenable_i);
              s_d.gsin[0] = wmerge[HI_LSB +: GAIN_W];
              s_d.gcos[0] = wmerge[LO_LSB +: GAIN_W];
            end
            ADDR_GAIN_CH2: begin
              wmerge      = be_merge({5'h00, s_q.gsin[1], 5'h00, s_q.gcos[1]},
                                     avs_writedata_i, avs_byteenable_i);
              s_d.gsin[1] = wmerge[HI_LSB +: GAIN_W];
              s_d.gcos[1] = wmerge[LO_LSB +: GAIN_W];
            end
            ADDR_OFFS_CH1: begin
              {s_d.osin[0], s_d.ocos[0]} = be_merge({s_q.osin[0], s_q.ocos[0]},
                                                    avs_writedata_i, avs_byteenable_i);
            end
            ADDR_OFFS_CH2: begin
              {s_d.osin[1], s_d.ocos[1]} = be_merge({s_q.osin[1], s_q.ocos[1]},
                                                    avs_writedata_i, avs_byteenable_i);
            end
            // Result and status words ignore writes
            default: begin
            end
          endcase
        end
      end
      default: begin
        s_d.bus = SCCR_BUS_IDLE;
      end
    endcase
    // Pin edge or command refreshes calibration snapshots
    s_d.trig = (trig_i && !s_q.trig_prev) || cmd_trig;
    s_d.wreq = (s_d.bus != SCCR_BUS_ACK);
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q.bus       <= SCCR_BUS_IDLE;
      s_q.wreq      <= 1'b1;
      s_q.rdata     <= 32'h0000_0000;
      s_q.mode      <= MODE_RESET;
      s_q.rate      <= RATE_RESET;
      s_q.gsin      <= {NUM_CH{GAIN_RESET}};
      s_q.gcos      <= {NUM_CH{GAIN_RESET}};
      s_q.osin      <= {NUM_CH{OFFS_RESET}};
      s_q.ocos      <= {NUM_CH{OFFS_RESET}};
      s_q.trig_prev <= 1'b0;
      s_q.trig      <= 1'b0;
      s_q.stat      <= 5'h00;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o    = s_q.rdata;
  assign avs_waitrequest_o = s_q.wreq;

  // ****************************************
  // Assertions
  // ****************************************
  logic req;
  assign req = avs_read_i || avs_write_i;

  property p_one_wait;
    @(posedge clock_i) disable iff (!rst_b_i)
      (req && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest not low one cycle");

  property p_dual;
    @(posedge clock_i) disable iff (!rst_b_i)
      (avs_read_i && avs_waitrequest_o && avs_address_i == ADDR_DUAL)
        |=> avs_readdata_o == $past(dual_w);
  endproperty
  a_dual: assert property (p_dual) else $error("combined angle word wrong");

  property p_dual_map;
    @(posedge clock_i) disable iff (!rst_b_i)
      (avs_read_i && avs_waitrequest_o && avs_address_i == ADDR_DUAL)
        |=> avs_readdata_o == {$past(angle_w[1]), $past(angle_w[0])};
  endproperty
  a_dual_map: assert property (p_dual_map) else $error("channel angles swapped");

  property p_status;
    @(posedge clock_i) disable iff (!rst_b_i)
      (avs_read_i && avs_waitrequest_o && avs_address_i == ADDR_PMEM && $stable(write_active_i))
        |=> avs_readdata_o[18] == $past(write_active_i, 2) && avs_readdata_o[15:0] == 16'h0000;
  endproperty
  a_status: assert property (p_status) else $error("write flag not at bit 18");

  property p_busy_pos;
    @(posedge clock_i) disable iff (!rst_b_i)
      memory_busy_i |=> s_q.stat[1] ##1 1'b1;
  endproperty
  a_busy_pos: assert property (p_busy_pos) else $error("busy flag not captured");

  property p_read_no_effect;
    @(posedge clock_i) disable iff (!rst_b_i)
      (avs_read_i && sample_valid_i == '0 && !s_q.trig && !$past(s_q.trig))
        |=> $stable(angle_w) && $stable(hi_w[0][15:0]) || !calib;
  endproperty
  a_read_no_effect: assert property (p_read_no_effect) else $error("read disturbed results");

  property p_angle_range;
    @(posedge clock_i) disable iff (!rst_b_i)
      ($past(sample_valid_i[0]) && $stable(s_q.rate) && s_q.rate != 16'h0000)
        |-> angle_w[0] < s_q.rate;
  endproperty
  a_angle_range: assert property (p_angle_range) else $error("angle beyond rate");

  property p_sm_format;
    @(posedge clock_i) disable iff (!rst_b_i)
      $past(sample_valid_i[1]) |-> corr_w[1][30] == 1'b0 && corr_w[1][14] == 1'b0;
  endproperty
  a_sm_format: assert property (p_sm_format) else $error("magnitude overflow bit set");

  property p_dev_pass;
    @(posedge clock_i) disable iff (!rst_b_i)
      (!calib ##1 !calib) |=> hi_w[0] == $past(deviation_i[0]);
  endproperty
  a_dev_pass: assert property (p_dev_pass) else $error("deviation not shown");

  property p_quad_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
      (calib && !s_q.trig) [*3] |=> $stable(hi_w[0]);
  endproperty
  a_quad_hold: assert property (p_quad_hold) else $error("quadrant view moved without trigger");

  property p_calib_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
      (calib && !s_q.trig) |=> $stable(corr_w);
  endproperty
  a_calib_hold: assert property (p_calib_hold) else $error("corrected word moved untriggered");

  property p_ro_write;
    @(posedge clock_i) disable iff (!rst_b_i)
      (avs_write_i && !avs_waitrequest_o && avs_address_i >= ADDR_CSP_CH1
       && sample_valid_i == '0 && !s_q.trig) |=> $stable(corr_w) && $stable(angle_w);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write changed a result word");

  property p_idle_wait;
    @(posedge clock_i) disable iff (!rst_b_i)
      (!req && avs_waitrequest_o) |=> avs_waitrequest_o;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("waitrequest dropped while idle");

  property p_lock_pos;
    @(posedge clock_i) disable iff (!rst_b_i)
      memory_locked_i |=> s_q.stat[0];
  endproperty
  a_lock_pos: assert property (p_lock_pos) else $error("locked flag not captured");

  c_calib_trig: cover property (@(posedge clock_i) disable iff (!rst_b_i) calib && s_q.trig);
  c_settled:    cover property (@(posedge clock_i) disable iff (!rst_b_i)
                                deviation_i[0] == DEV_SETTLED);
  c_read_dual:  cover property (@(posedge clock_i) disable iff (!rst_b_i)
                                avs_read_i && !avs_waitrequest_o && avs_address_i == ADDR_DUAL);
  c_busy_read:  cover property (@(posedge clock_i) disable iff (!rst_b_i)
                                s_q.stat[1] && avs_read_i && avs_address_i == ADDR_PMEM);
endmodule
`default_nettype wire

// ### tb/sccr_sensor_model.sv
// Sensor front end model: sampled sine, cosine, turn and deviation per channel
`timescale 1ns/1ps
`default_nettype none
module sccr_sensor_model (
  // Clock
  input  wire logic        clock_i,
  // Sampled channel outputs
  output logic [1:0]       valid_o,
  output logic [1:0][15:0] sin_o,
  output logic [1:0][15:0] cos_o,
  output logic [1:0][15:0] turn_o,
  output logic [1:0][15:0] dev_o
);
  initial begin
    valid_o = 2'h0;
    sin_o = 32'h0000_0000;
    cos_o = 32'h0000_0000;
    turn_o = 32'h0000_0000;
    dev_o = 32'h0000_0000;
  end
  // One-cycle pulse; converter words hold until the next sample
  task automatic send(input int ch, input logic [15:0] t, input logic [15:0] s,
                      input logic [15:0] c);
    valid_o[ch] <= 1'b1;
    turn_o[ch] <= t;
    sin_o[ch] <= s;
    cos_o[ch] <= c;
    @(posedge clock_i);
    valid_o[ch] <= 1'b0;
  endtask
  task automatic set_dev(input int ch, input logic [15:0] d);
    dev_o[ch] <= d;
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Testbench: register readout against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sccr_pkg::*;
  logic             clock, rst_b, av_rd, av_wr, av_wait, trig, lv, er, wa, bsy, lk;
  logic [7:0]       addr;
  logic [3:0]       be;
  logic [31:0]      wdata, rdata;
  logic [1:0]       sv;
  logic [1:0][15:0] rs, rc, tn, dv;
  logic [15:0]      trn[2];
  int miscompares, compares, rate, mode, k, i;
  int ang[2], stp[2], pq[2], qc[2], qv[2], cs[2], cc[2], dev[2], prim[2];
  int gs[2], gc[2], os[2], oc[2], test_reserved_bit[2], rcv[2];

  sccr_top DUT (.clock_i(clock), .rst_b_i(rst_b), .avs_address_i(addr), .avs_read_i(av_rd),
    .avs_write_i(av_wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(av_wait), .sample_valid_i(sv),
    .raw_sin_i(rs), .raw_cos_i(rc), .turn_i(tn), .deviation_i(dv), .trig_i(trig),
    .mem_load_valid_i(lv), .erase_active_i(er), .write_active_i(wa),
    .memory_busy_i(bsy), .memory_locked_i(lk));
  sccr_sensor_model u_sensor (.clock_i(clock), .valid_o(sv), .sin_o(rs), .cos_o(rc),
    .turn_o(tn), .dev_o(dv));

  //****************************************
  // Bus, compare and model helpers
  //****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    be <= b;
    av_rd <= ~w;
    av_wr <= w;
    do begin
      @(posedge clock);
      n++;
    end while (av_wait !== 1'b0 && n < 100);
    q = rdata;
    if (n >= 100) miscompares++;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] x;
    bus(1'b1, a, d, b, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, 4'hF, x);
    chk(x, exp);
  endtask
  function automatic int sm(int raw, int off, int g);
    int v;
    int m;
    v = ((raw + off) * (1024 + g)) >>> 11;
    m = (v < 0) ? -v : v;
    if (m > 16383) m = 16383;
    return ((v < 0) ? 16'h8000 : 16'h0000) | m;
  endfunction
  function automatic logic [31:0] expw(int j);
    int c;
    c = j % 2;
    case (j)
      0, 1: return {cs[c][15:0], cc[c][15:0]};
      2, 3: return {stp[c][15:0], ang[c][15:0]};
      4, 5: return {(mode == 5) ? qv[c][15:0] : dev[c][15:0], ang[c][15:0]};
      6: return {ang[1][15:0], ang[0][15:0]};
      default: return {11'h000, lv, er, wa, bsy, lk, 16'h0000};
    endcase
  endfunction
  task automatic check_all();
    for (int j = 0; j < 8; j++) rd(8'(8'h18 + 4 * j), expw(j));
  endtask
  task automatic snap(input int c, input int withq);
    cs[c] = sm(test_reserved_bit[c], os[c], gs[c]);
    cc[c] = sm(rcv[c], oc[c], gc[c]);
    if (withq) qv[c] = qc[c];
  endtask
  task automatic set_corr(input int c);
    logic [31:0] g;
    gs[c] = $urandom_range(2047);
    gc[c] = $urandom_range(2047);
    os[c] = int'($urandom_range(5459)) - 2730;
    oc[c] = int'($urandom_range(5459)) - 2730;
    g = {5'h00, 11'(gs[c]), 5'h00, 11'(gc[c])};
    wr(c ? ADDR_GAIN_CH2 : ADDR_GAIN_CH1, {16'($urandom), g[15:0]}, 4'h3);
    wr(c ? ADDR_GAIN_CH2 : ADDR_GAIN_CH1, {g[31:16], 16'($urandom)}, 4'hC);
    wr(c ? ADDR_OFFS_CH2 : ADDR_OFFS_CH1, {16'(os[c]), 16'(oc[c])}, 4'hF);
  endtask
  task automatic smp(input int ch);
    int a;
    int d;
    int q;
    logic [15:0] s;
    logic [15:0] c;
    trn[ch] = trn[ch] + 16'(int'($urandom_range(16'h1FFE)) - 16'h0FFF);
    s = 16'($urandom_range(16'h3FFF)) - 16'h2000;
    c = 16'($urandom_range(16'h3FFF)) - 16'h2000;
    u_sensor.send(ch, trn[ch], s, c);
    a = (int'(trn[ch]) * rate) >> 16;
    d = prim[ch] ? a - ang[ch] : 0;
    if (d > rate / 2) d -= rate;
    if (d < -rate / 2) d += rate;
    q = trn[ch][15:14];
    if (prim[ch] && q == (pq[ch] + 1) % 4) qc[ch]++;
    if (prim[ch] && q == (pq[ch] + 3) % 4) qc[ch]--;
    ang[ch] = a;
    stp[ch] = d;
    pq[ch] = q;
    prim[ch] = 1;
    test_reserved_bit[ch] = $signed(s);
    rcv[ch] = $signed(c);
    if (mode != 5) snap(ch, 0);
    @(posedge clock);
  endtask
  task automatic close_out();
    $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  //****************************************
  // Clock, watchdog and test sequence
  //****************************************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #(8 * 60000);
    miscompares++;
    close_out();
  end
  initial begin
    void'($urandom(7));
    {rst_b, av_rd, av_wr, trig, lv, er, wa, bsy, lk} = 9'h000;
    addr = 8'h00;
    be = 4'hF;
    wdata = 32'h0000_0000;
    trn[0] = 16'h2000;
    trn[1] = 16'h2000;
    rate = 16'h1000;
    gs = '{1024, 1024};
    gc = '{1024, 1024};
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    check_all();
    wr(ADDR_CTRL, {16'h0E10, 16'h0000}, 4'hF);
    rate = 16'h0E10;
    dev[0] = 16'h0141;
    dev[1] = $urandom_range(16'hFFFF);
    u_sensor.set_dev(0, 16'(dev[0]));
    u_sensor.set_dev(1, 16'(dev[1]));
    for (k = 0; k < 30; k++) begin
      if (k % 10 == 0) set_corr(k / 10 % 2);
      smp(0);
      smp(1);
      check_all();
    end
    for (k = 0; k < 8; k++) begin
      {lv, er, wa, bsy, lk} <= (k < 5) ? 5'(1 << k) : 5'($urandom);
      repeat (2) @(posedge clock);
      rd(ADDR_PMEM, expw(7));
    end
    {lv, er, wa, bsy, lk} <= 5'h00;
    for (i = 0; i < 9; i++) wr(8'(8'h18 + 4 * i), 32'hFFFF_FFFF, 4'hF);
    rd(8'h3C, 32'h0000_0000);
    check_all();
    wr(ADDR_CTRL, {16'h0E10, 16'h0005}, 4'hF);
    mode = 5;
    for (k = 0; k < 4; k++) begin
      smp(0);
      smp(1);
      check_all();
    end
    wr(ADDR_CMD, 32'h0000_0001, 4'hF);
    snap(0, 1);
    snap(1, 1);
    check_all();
    smp(0);
    smp(1);
    trig <= 1'b1;
    repeat (2) @(posedge clock);
    trig <= 1'b0;
    @(posedge clock);
    snap(0, 1);
    snap(1, 1);
    check_all();
    wr(ADDR_CTRL, {16'h0E10, 16'h0000}, 4'hF);
    mode = 0;
    smp(0);
    smp(1);
    check_all();
    close_out();
  end
endmodule
`default_nettype wire
